/* include/cefi_pkg.sv */
// package of constants and carrier types for the can error and interrupt flag block
package cefi_pkg;

    // ------------------------------------------------------------
    // host op-codes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_RD_ERROR_STATE = 8'hdc;
    localparam logic [7:0] OP_RD_EVENT_FLAGS = 8'hde;
    localparam logic [7:0] OP_WR_ENABLE_MASK = 8'h1c;
    localparam logic [7:0] OP_RD_ENABLE_MASK = 8'he4;
    localparam logic [7:0] OP_NONE           = 8'h00;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ERROR_STATE_RST = 8'h00;
    localparam logic [7:0] EVENT_FLAGS_RST = 8'h00;
    localparam logic [7:0] ENABLE_MASK_RST = 8'h00;
    localparam logic [3:0] MATCH_CODE_RST  = 4'h0;

    // ------------------------------------------------------------
    // error state field positions
    // ------------------------------------------------------------
    localparam int ERR_BUS_OFF_BIT   = 7;
    localparam int ERR_TX_PASS_BIT   = 6;
    localparam int ERR_RX_PASS_BIT   = 5;
    localparam int ERR_BIT_MISM_BIT  = 4;
    localparam int ERR_FORM_BIT      = 3;
    localparam int ERR_CHECKSUM_BIT  = 2;
    localparam int ERR_ACK_BIT       = 1;
    localparam int ERR_STUFF_BIT     = 0;

    // ------------------------------------------------------------
    // event flag field positions
    // ------------------------------------------------------------
    localparam int FLG_TEMP_RX_BIT   = 7;
    localparam int FLG_FILT_RX_BIT   = 6;
    localparam int FLG_TX_DONE_BIT   = 5;
    localparam int FLG_PROTO_BIT     = 4;
    localparam int FLG_MODE_BIT      = 3;
    localparam int FLG_WAKE_BIT      = 2;
    localparam int FLG_FILT1_BIT     = 1;
    localparam int FLG_FILT0_BIT     = 0;

    // ------------------------------------------------------------
    // counter thresholds
    // ------------------------------------------------------------
    localparam logic [8:0] CNT_PASSIVE_MIN = 9'h080;  // 128
    localparam logic [8:0] CNT_PASSIVE_MAX = 9'h0ff;  // 255
    localparam logic [3:0] RECOV_RUN_LEN   = 4'hb;    // 11 recessive bits
    localparam logic [7:0] RECOV_SEQ_CNT   = 8'h80;   // 128 runs

    // ------------------------------------------------------------
    // operating modes and filter codes
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_NORMAL     = 3'h0;
    localparam logic [2:0] MODE_SLEEP      = 3'h1;
    localparam logic       MATCH_VALID     = 1'b1;

    // bus bit sample from the protocol engine
    typedef struct packed {
        logic bit_strobe;  // one pulse per sampled bit
        logic tx_active;   // node is transmitting a frame
        logic tx_level;    // level driven, 1 = recessive
        logic rx_level;    // level sampled, 1 = recessive
    } cefi_link_s;

    // receive-side protocol faults, one-cycle pulses
    typedef struct packed {
        logic form;
        logic checksum;
        logic ack;
        logic stuff;
    } cefi_fault_s;

    // frame events, one-cycle pulses
    typedef struct packed {
        logic       temp_rx;
        logic       filt_rx;
        logic       tx_done;
        logic       filt_pass;
        logic [2:0] filt_num;
    } cefi_frame_s;

    typedef enum logic [0:0] {
        CEFI_MODE_IDLE,
        CEFI_MODE_DRAIN
    } cefi_mode_e;

endpackage

/* design/cefi_recovery.sv */
// bus-off recovery detector: counts runs of recessive bits
`timescale 1ns/1ps
module cefi_recovery
    import cefi_pkg::*;
(
    // clock and reset
    input  wire logic CLK_SYS,
    input  wire logic RST_N,
    // control
    input  wire logic ENABLE,
    input  wire logic BIT_STROBE,
    input  wire logic RX_LEVEL,
    // result
    output logic      DONE
);

    logic [3:0] run_ff;
    logic [7:0] seq_ff;
    logic       done_ff;

    // ------------------------------------------------------------
    // run and sequence counters
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            run_ff  <= 4'h0;
            seq_ff  <= 8'h00;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (!ENABLE) begin
                run_ff <= 4'h0;
                seq_ff <= 8'h00;
            end else if (BIT_STROBE) begin
                if (!RX_LEVEL) begin
                    run_ff <= 4'h0;  // dominant bit breaks the run
                end else if (run_ff == RECOV_RUN_LEN - 4'h1) begin
                    run_ff <= 4'h0;
                    if (seq_ff == RECOV_SEQ_CNT - 8'h01) begin
                        seq_ff  <= 8'h00;
                        done_ff <= 1'b1;
                    end else begin
                        seq_ff <= seq_ff + 8'h01;
                    end
                end else begin
                    run_ff <= run_ff + 4'h1;
                end
            end
        end
    end

    assign DONE = done_ff;

endmodule

/* design/cefi_top.sv */
// error state, interrupt flags, enable mask and interrupt pin of the can controller
`timescale 1ns/1ps
//
// Contract
// - error register is read-only via op-code 0xdc; writes do nothing
// - error bits zero at power-up, kept through a device reset
// - host read of error register clears bits 4:0 only
// - bit 7 sets when transmit error count exceeds 255
// - bit 7 clears after 128 runs of 11 recessive bits
// - bit 6 high while transmit count is 128 to 255
// - bit 5 high while receive count is 128 to 255
// - bit 4 sets on driven versus sampled mismatch while transmitting
// - bit 3 sets on a form violation in a received frame
// - bit 2 sets on a checksum mismatch in a received frame
// - bit 1 sets on an acknowledge error
// - bit 0 sets on a stuffing violation
// - flag register read via 0xde clears the flags it returned and the pin
// - pin latches high on any enabled set flag until read
// - flag 7 sets on a valid frame in the temporary buffer
// - flag 6 sets on a filtered frame moved into the fifo
// - flag 5 sets on each successful transmission
// - flag 4 sets on any protocol error
// - flag 2 sets when bus activity wakes the device from sleep
// - flags 1 and 0 on filter one or zero pass; code 1001 or 1000
// - enable mask written with 0x1c, read with 0xe4, bitwise gating
module cefi_top
    import cefi_pkg::*;
(
    // clock and resets
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    input  wire logic        DEV_RESET,
    // host op-code port
    input  wire logic        OP_VALID,
    input  wire logic [7:0]  OP_CODE,
    input  wire logic [7:0]  OP_WDATA,
    input  wire logic        OP_END,
    output logic [7:0]       RD_DATA,
    output logic             RD_VALID,
    // protocol engine reports
    input  wire logic [8:0]  TX_ERR_CNT,
    input  wire logic [8:0]  RX_ERR_CNT,
    input  wire cefi_link_s  LINK,
    input  wire cefi_fault_s FAULT,
    input  wire cefi_frame_s FRAME,
    // mode control
    input  wire logic        MODE_REQ,
    input  wire logic [2:0]  MODE_NEW,
    input  wire logic        TX_FIFO_EMPTY,
    input  wire logic        BUS_ACTIVITY,
    output logic [2:0]       MODE_CUR,
    // outputs
    output logic             INT,
    output logic             BUS_OFF,
    output logic             RECOVERY_DONE,
    output logic [3:0]       FILTER_MATCH_CODE
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [4:0] err_evt_ff;
    logic [2:0] err_state_ff;
    logic [7:0] flags_ff;
    logic [7:0] enable_mask_ff;
    logic       int_ff;
    logic [7:0] rd_data_ff;
    logic       rd_valid_ff;
    logic [7:0] pend_op_ff;
    logic [7:0] rd_capture_ff;
    logic [2:0] mode_cur_ff;
    logic [2:0] pend_mode_ff;
    logic       mode_evt_ff;
    logic       wake_evt_ff;
    logic [3:0] match_code_ff;
    cefi_mode_e mode_st_ff;
    logic [4:0] err_set;
    logic [7:0] flag_set;
    logic [4:0] err_clr;
    logic [7:0] flag_clr;
    logic [7:0] error_state;
    logic       bit_mismatch_error;
    logic       tx_over;
    logic       recov_done;
    logic       op_end_err;
    logic       op_end_flags;

    // ------------------------------------------------------------
    // event decode
    // ------------------------------------------------------------
    // mismatch between driven and sampled level while transmitting
    assign bit_mismatch_error = LINK.bit_strobe && LINK.tx_active
                                && (LINK.tx_level != LINK.rx_level);
    // protocol error sources in error register order
    assign err_set = {bit_mismatch_error, FAULT.form, FAULT.checksum,
                      FAULT.ack, FAULT.stuff};
    assign flag_set = {FRAME.temp_rx,
                       FRAME.filt_rx,
                       FRAME.tx_done,
                       |err_set,
                       mode_evt_ff,
                       wake_evt_ff,
                       FRAME.filt_pass && (FRAME.filt_num == 3'h1),
                       FRAME.filt_pass && (FRAME.filt_num == 3'h0)};
    assign tx_over      = TX_ERR_CNT > CNT_PASSIVE_MAX;
    assign op_end_err   = OP_END && (pend_op_ff == OP_RD_ERROR_STATE);
    assign op_end_flags = OP_END && (pend_op_ff == OP_RD_EVENT_FLAGS);
    // only bits the host actually saw are cleared
    assign err_clr  = op_end_err ? rd_capture_ff[4:0] : 5'h00;
    assign flag_clr = op_end_flags ? rd_capture_ff : 8'h00;
    assign error_state = {err_state_ff, err_evt_ff};

    // ------------------------------------------------------------
    // bus-off recovery
    // ------------------------------------------------------------
    cefi_recovery u_recovery (
        .CLK_SYS    (CLK_SYS),
        .RST_N      (RST_N),
        .ENABLE     (err_state_ff[2]),
        .BIT_STROBE (LINK.bit_strobe),
        .RX_LEVEL   (LINK.rx_level),
        .DONE       (recov_done)
    );

    // ------------------------------------------------------------
    // error register, power-up reset only
    // ------------------------------------------------------------
    // protocol error bits: set wins over a clearing read
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            err_evt_ff <= ERROR_STATE_RST[4:0];
        end else begin
            err_evt_ff <= (err_evt_ff & ~err_clr) | err_set;
        end
    end

    // fault confinement state bits, untouched by reads and device reset
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            err_state_ff <= ERROR_STATE_RST[7:5];
        end else begin
            if (recov_done) begin
                err_state_ff[2] <= 1'b0;
            end else if (tx_over) begin
                err_state_ff[2] <= 1'b1;
            end
            err_state_ff[1] <= (TX_ERR_CNT >= CNT_PASSIVE_MIN)
                               && (TX_ERR_CNT <= CNT_PASSIVE_MAX);
            err_state_ff[0] <= (RX_ERR_CNT >= CNT_PASSIVE_MIN)
                               && (RX_ERR_CNT <= CNT_PASSIVE_MAX);
        end
    end

    // ------------------------------------------------------------
    // event flags and interrupt pin
    // ------------------------------------------------------------
    // flags clear on read completion and device reset; new events win over the read, device reset wins over new events
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            flags_ff <= EVENT_FLAGS_RST;
        end else if (DEV_RESET) begin
            flags_ff <= EVENT_FLAGS_RST;
        end else begin
            flags_ff <= (flags_ff & ~flag_clr) | flag_set;
        end
    end

    // pin latches on any enabled flag, drops after the flag read
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            int_ff <= 1'b0;
        end else if (DEV_RESET) begin
            int_ff <= 1'b0;
        end else if (|(flags_ff & enable_mask_ff & ~flag_clr)) begin
            int_ff <= 1'b1;
        end else if (op_end_flags) begin
            int_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // host op-code handling
    // ------------------------------------------------------------
    // enable mask write
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            enable_mask_ff <= ENABLE_MASK_RST;
        end else if (DEV_RESET) begin
            enable_mask_ff <= ENABLE_MASK_RST;
        end else if (OP_VALID && (OP_CODE == OP_WR_ENABLE_MASK)) begin
            enable_mask_ff <= OP_WDATA;
        end
    end

    // read data, capture and pending read op-code
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            rd_data_ff    <= 8'h00;
            rd_valid_ff   <= 1'b0;
            pend_op_ff    <= OP_NONE;
            rd_capture_ff <= 8'h00;
        end else begin
            rd_valid_ff <= 1'b0;
            if (OP_END) begin
                pend_op_ff <= OP_NONE;
            end
            if (OP_VALID) begin
                pend_op_ff <= OP_CODE;
                case (OP_CODE)
                    OP_RD_ERROR_STATE: begin
                        rd_data_ff    <= error_state;
                        rd_capture_ff <= error_state;
                        rd_valid_ff   <= 1'b1;
                    end
                    OP_RD_EVENT_FLAGS: begin
                        rd_data_ff    <= flags_ff;
                        rd_capture_ff <= flags_ff;
                        rd_valid_ff   <= 1'b1;
                    end
                    OP_RD_ENABLE_MASK: begin
                        rd_data_ff    <= enable_mask_ff;
                        rd_capture_ff <= 8'h00;
                        rd_valid_ff   <= 1'b1;
                    end
                    default: begin
                        rd_capture_ff <= 8'h00;  // other codes belong elsewhere
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // mode change and wake-up
    // ------------------------------------------------------------
    // requested mode waits for the transmit fifo to drain
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            mode_st_ff   <= CEFI_MODE_IDLE;
            mode_cur_ff  <= MODE_NORMAL;
            pend_mode_ff <= MODE_NORMAL;
            mode_evt_ff  <= 1'b0;
            wake_evt_ff  <= 1'b0;
        end else begin
            mode_evt_ff <= 1'b0;
            wake_evt_ff <= 1'b0;
            if (DEV_RESET) begin
                mode_st_ff  <= CEFI_MODE_IDLE;
                mode_cur_ff <= MODE_NORMAL;
            end else begin
                case (mode_st_ff)
                    CEFI_MODE_IDLE: begin
                        if (MODE_REQ) begin
                            pend_mode_ff <= MODE_NEW;
                            mode_st_ff   <= CEFI_MODE_DRAIN;
                        end else if (BUS_ACTIVITY && (mode_cur_ff == MODE_SLEEP)) begin
                            mode_cur_ff <= MODE_NORMAL;
                            wake_evt_ff <= 1'b1;
                        end
                    end
                    CEFI_MODE_DRAIN: begin
                        if (TX_FIFO_EMPTY && !LINK.tx_active) begin
                            mode_cur_ff <= pend_mode_ff;
                            mode_evt_ff <= 1'b1;
                            mode_st_ff  <= CEFI_MODE_IDLE;
                        end
                    end
                    default: begin
                        mode_st_ff <= CEFI_MODE_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // filter match code
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            match_code_ff <= MATCH_CODE_RST;
        end else if (FRAME.filt_pass) begin
            match_code_ff <= {MATCH_VALID, FRAME.filt_num};
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign RD_DATA           = rd_data_ff;
    assign RD_VALID          = rd_valid_ff;
    assign INT               = int_ff;
    assign BUS_OFF           = err_state_ff[2];
    assign RECOVERY_DONE     = recov_done;
    assign MODE_CUR          = mode_cur_ff;
    assign FILTER_MATCH_CODE = match_code_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_bus_off_flag_set: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        (tx_over && !recov_done) |=> BUS_OFF)
        else $error("bus-off bit not set after count overflow");

    a_bus_off_flag_hold: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        (BUS_OFF && !recov_done) |=> BUS_OFF)
        else $error("bus-off bit dropped without recovery");

    a_tx_passive: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        (TX_ERR_CNT >= 9'h080 && TX_ERR_CNT <= 9'h0ff) |=> error_state[6])
        else $error("transmit passive bit missing");

    a_rx_passive: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        (RX_ERR_CNT > 9'h0ff || RX_ERR_CNT < 9'h080) |=> !error_state[5])
        else $error("receive passive bit set out of range");

    a_bit_mismatch: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        (LINK.bit_strobe && LINK.tx_active && LINK.tx_level != LINK.rx_level && !DEV_RESET)
        |=> error_state[4] && flags_ff[4])
        else $error("bit mismatch not recorded");

    a_stuff_err: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        FAULT.stuff |=> error_state[0])
        else $error("stuffing error not recorded");

    a_err_read_clr: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        (op_end_err && err_set == 5'h00) |=> ((err_evt_ff & $past(rd_capture_ff[4:0])) == 5'h00))
        else $error("error bits not cleared by read");

    a_flag_read_clr: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        (op_end_flags && flag_set == 8'h00) |=> ((flags_ff & $past(rd_capture_ff)) == 8'h00))
        else $error("flags not cleared by read");

    a_int_latch: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        (|(flags_ff & enable_mask_ff) && !op_end_flags && !DEV_RESET)
        |=> INT ##1 (INT || $past(op_end_flags) || $past(DEV_RESET)))
        else $error("interrupt pin not latched");

    a_temp_rx_wins: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        (FRAME.temp_rx && !DEV_RESET) |=> flags_ff[7])
        else $error("temporary buffer event lost");

    a_mode_drain: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        mode_evt_ff |-> $past(TX_FIFO_EMPTY) && $past(mode_st_ff == CEFI_MODE_DRAIN))
        else $error("mode changed before transmit fifo drained");

    a_mask_write: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        (OP_VALID && OP_CODE == 8'h1c && !DEV_RESET) |=> enable_mask_ff == $past(OP_WDATA))
        else $error("enable mask write lost");

    a_filter_code: assert property (
        @(posedge CLK_SYS) disable iff (!RST_N)
        (FRAME.filt_pass && FRAME.filt_num == 3'h1) |=> FILTER_MATCH_CODE == 4'h9)
        else $error("filter one code wrong");

endmodule

/* verification/cefi_host.sv */
// host model: drives op-code accesses into the block
`timescale 1ns/1ps
module cefi_host (
    // clock
    input  wire logic       clk,
    // op-code port
    output logic            op_valid,
    output logic [7:0]      op_code,
    output logic [7:0]      op_wdata,
    output logic            op_end,
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_valid
);
    // port idle from time zero
    initial begin
        op_valid = 1'b0;
        op_code = 8'h00;
        op_wdata = 8'h00;
        op_end = 1'b0;
    end
    // one byte access, entered at a falling edge
    task automatic access(input logic [7:0] c, input logic [7:0] w,
                          output logic [7:0] r, output logic v);
        op_valid = 1'b1;
        op_code = c;
        op_wdata = w;
        @(negedge clk);
        op_valid = 1'b0;
        op_code = ~c;  // stale lines never repeat the last value
        op_wdata = ~w;
        v = rd_valid;
        r = rd_data;
        op_end = 1'b1;
        @(negedge clk);
        op_end = 1'b0;
        repeat (2) @(negedge clk);
    endtask
endmodule

/* verification/cefi_top_bench.sv */
// self-checking bench for the error state and interrupt flag block
`timescale 1ns/1ps
module cefi_top_bench;
    import cefi_pkg::*;
    logic        clk, rst_n, dev_reset, op_valid, op_end, rd_valid, v;
    logic        mode_req, fifo_empty, bus_act, int_o, bus_off, rec_done;
    logic [7:0]  op_code, op_wdata, rd_data, r;
    logic [8:0]  tx_cnt, rx_cnt;
    logic [2:0]  mode_new, mode_cur;
    logic [3:0]  match;
    cefi_link_s  link;
    cefi_fault_s fault;
    cefi_frame_s frame;
    int          fail_count, check_count, cyc;
    // clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    cefi_top DUT (.CLK_SYS(clk), .RST_N(rst_n), .DEV_RESET(dev_reset),
        .OP_VALID(op_valid), .OP_CODE(op_code), .OP_WDATA(op_wdata), .OP_END(op_end),
        .RD_DATA(rd_data), .RD_VALID(rd_valid), .TX_ERR_CNT(tx_cnt), .RX_ERR_CNT(rx_cnt),
        .LINK(link), .FAULT(fault), .FRAME(frame), .MODE_REQ(mode_req),
        .MODE_NEW(mode_new), .TX_FIFO_EMPTY(fifo_empty), .BUS_ACTIVITY(bus_act),
        .MODE_CUR(mode_cur), .INT(int_o), .BUS_OFF(bus_off), .RECOVERY_DONE(rec_done),
        .FILTER_MATCH_CODE(match));
    cefi_host HOST (.clk(clk), .op_valid(op_valid), .op_code(op_code),
        .op_wdata(op_wdata), .op_end(op_end), .rd_data(rd_data), .rd_valid(rd_valid));
    // compare and count
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] c, input logic [7:0] e);
        HOST.access(c, 8'h00, r, v);
        chk("read valid", 8'h01, {7'h00, v});
        chk($sformatf("read %h", c), e, r);
    endtask
    // drop event pulses after one cycle, then let n more edges pass
    task automatic idle(input int n);
        @(negedge clk);
        fault = '0;
        frame = '0;
        link.bit_strobe = 1'b0;
        mode_req = 1'b0;
        bus_act = 1'b0;
        repeat (n) @(negedge clk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 12000) begin
            fail_count++;
            tally_and_finish;
        end
    end
    // scenarios in order
    initial begin
        {rst_n, dev_reset, mode_req, bus_act, fail_count, check_count, cyc} = '0;
        {tx_cnt, rx_cnt, fault, frame, mode_new} = '0;
        link = 4'b0011;
        fifo_empty = 1'b1;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        rd(OP_RD_ERROR_STATE, 8'h00);
        rd(OP_RD_EVENT_FLAGS, 8'h00);
        HOST.access(8'h55, 8'h00, r, v);
        chk("unknown op", 8'h00, {7'h00, v});
        HOST.access(OP_WR_ENABLE_MASK, 8'h20, r, v);
        rd(OP_RD_ENABLE_MASK, 8'h20);
        fault.stuff = 1'b1;
        idle(1);
        chk("int masked", 8'h00, {7'h00, int_o});
        frame.tx_done = 1'b1;
        idle(1);
        chk("int set", 8'h01, {7'h00, int_o});
        rd(OP_RD_EVENT_FLAGS, 8'h30);
        chk("int cleared", 8'h00, {7'h00, int_o});
        rd(OP_RD_EVENT_FLAGS, 8'h00);
        fault = 4'hf;
        link = 4'b1101;
        idle(1);
        link = 4'b0011;
        rd(OP_RD_ERROR_STATE, 8'h1f);
        rd(OP_RD_ERROR_STATE, 8'h00);
        rd(OP_RD_EVENT_FLAGS, 8'h10);
        frame = 7'b1101001;
        idle(1);
        chk("match code", 8'h09, {4'h0, match});
        frame = 7'b0001000;
        idle(1);
        chk("match code", 8'h08, {4'h0, match});
        rd(OP_RD_EVENT_FLAGS, 8'hc3);
        tx_cnt = 9'h080;
        rx_cnt = 9'h0ff;
        idle(1);
        rd(OP_RD_ERROR_STATE, 8'h60);
        tx_cnt = 9'h100;
        rx_cnt = 9'h07f;
        idle(1);
        chk("bus off", 8'h01, {7'h00, bus_off});
        rd(OP_RD_ERROR_STATE, 8'h80);
        tx_cnt = 9'h000;
        repeat (1407) begin
            link.bit_strobe = 1'b1;
            idle(1);
        end
        chk("bus off held", 8'h01, {7'h00, bus_off});
        link.bit_strobe = 1'b1;
        idle(0);
        chk("recovery done", 8'h01, {7'h00, rec_done});
        idle(0);
        chk("bus off", 8'h00, {7'h00, bus_off});
        HOST.access(OP_WR_ENABLE_MASK, 8'hff, r, v);
        fault.form = 1'b1;
        idle(0);
        dev_reset = 1'b1;
        @(negedge clk);
        dev_reset = 1'b0;
        rd(OP_RD_ERROR_STATE, 8'h08);
        rd(OP_RD_ENABLE_MASK, 8'h00);
        HOST.access(OP_WR_ENABLE_MASK, 8'h0c, r, v);
        {fifo_empty, mode_req, mode_new} = {2'b01, MODE_SLEEP};
        idle(3);
        chk("mode held", 8'h00, {5'h00, mode_cur});
        fifo_empty = 1'b1;
        idle(2);
        chk("mode", 8'h01, {5'h00, mode_cur});
        chk("int mode", 8'h01, {7'h00, int_o});
        rd(OP_RD_EVENT_FLAGS, 8'h08);
        bus_act = 1'b1;
        idle(2);
        chk("mode woken", 8'h00, {5'h00, mode_cur});
        rd(OP_RD_EVENT_FLAGS, 8'h04);
        frame.tx_done = 1'b1;
        idle(1);
        fork
            rd(OP_RD_EVENT_FLAGS, 8'h20);
            begin
                @(negedge clk);
                frame.tx_done = 1'b1;
                idle(0);
            end
        join
        rd(OP_RD_EVENT_FLAGS, 8'h20);
        tally_and_finish;
    end
endmodule
